// *** design/dic_defines.svh ***
`ifndef DIC_DEFINES_SVH
`define DIC_DEFINES_SVH
// timing
`define CLK_PERIOD_NS      25
`define MS_NS              1000000
`define TICK_MS_CYCLES     (`MS_NS / `CLK_PERIOD_NS)
`define REFRESH_NS         6500000
`define REFRESH_CYCLES     (`REFRESH_NS / `CLK_PERIOD_NS)
`define INPUT_MAX_HZ       50
// register indices (word addresses)
`define REG_MODE           8'h00
`define REG_INVERT         8'h01
`define REG_SIM_ENABLE     8'h02
`define REG_SIM_VALUE      8'h03
`define REG_SIM_STATUS     8'h04
`define REG_SUBST_VALUE    8'h05
`define REG_FAULT_FORCE    8'h06
`define REG_ON_DELAY_BASE  8'h10
`define REG_OFF_DELAY_BASE 8'h20
`define REG_IMAGE          8'h30
`define REG_VALUES         8'h31
`define REG_TYPE           8'h32
`define REG_MODE_HI        8'h07
// modbus map in direct and legacy forms; the com unit decodes these, both sides must use one form
`define FC_READ_DISCRETE   8'h02 // see RULE_11
`define FC_READ_HOLDING    8'h03 // see RULE_12
`define FC_READ_INPUT      8'h04 // see RULE_15
`define ALLOC_BIT_DIRECT   16'h0000 // see RULE_16
`define ALLOC_BIT_LEGACY   16'h2711 // see RULE_11
`define ALLOC_WORD_DIRECT  16'h0400 // see RULE_12
`define ALLOC_WORD_LEGACY  16'hB3B1
`define SLOT_BIT_DIRECT    16'h1400 // see RULE_13
`define SLOT_BIT_LEGACY    16'h3E81
`define SLOT_STAT_DIRECT   16'h0800 // see RULE_14
`define SLOT_STAT_LEGACY   16'h36B1
`define MOD_STAT_DIRECT    16'h0300 // see RULE_15
`define MOD_STAT_LEGACY    16'h8980
`define MOD_TYPE_DIRECT    16'h0400
`define MOD_TYPE_LEGACY    16'h89E4
`define SLOT_BIT_STRIDE    16'h0010
`define SLOT_STAT_STRIDE   16'h0008
// image layout
`define IMG_COLLECTIVE_BIT 15
`define IMAGE_RESET        16'h8000
`define MODE_BITS          2
`define ERR_CURRENT        2'h0
`define ERR_SUBST          2'h1
`define ERR_LAST_VALID     2'h3
`endif

// *** design/dic_pkg.sv ***
package dic_pkg;
	typedef enum logic [1:0] {
		ERR_MODE_CURRENT    = 2'h0,
		ERR_MODE_SUBST      = 2'h1,
		ERR_MODE_LAST_VALID = 2'h3
	} err_mode_t;
	typedef enum logic [1:0] {
		FLT_LOW     = 2'h0,
		FLT_RISING  = 2'h1,
		FLT_HIGH    = 2'h3,
		FLT_FALLING = 2'h2
	} filt_state_t;
endpackage

// *** design/delay_filter.sv ***
`timescale 1ns/1ps
`include "dic_defines.svh"
// one channel: sync, on delay and off delay in whole milliseconds
module delay_filter
	import dic_pkg::*;
#(
	parameter int DW = 16
)(
	input  wire logic          clk_sys_i,
	input  wire logic          rstn_i,
	input  wire logic          tick_ms_i,
	input  wire logic          pin_i,
	input  wire logic [DW-1:0] on_delay_i,
	input  wire logic [DW-1:0] off_delay_i,
	output logic               level_o
);
	logic [2:0]    sync;
	logic          stable;
	logic          next_stable;
	filt_state_t   state;
	filt_state_t   next_state;
	logic [DW-1:0] cnt;
	logic [DW-1:0] next_cnt;
	logic          next_level;

	// three stage sync; first stage feeds only the second
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			sync   <= 3'h0;
			stable <= 1'b0;
		end
		else
		begin
			sync   <= {sync[1:0], pin_i};
			stable <= next_stable;
		end
	end

	always_comb
	begin
		next_stable = (sync[1] == sync[2]) ? sync[2] : stable;
	end

	// a zero delay passes the edge through at once
	always_comb
	begin
		next_state = state;
		next_cnt   = cnt;
		next_level = level_o;
		unique case (state)
			FLT_LOW:
			begin
				if (stable)
				begin
					if (on_delay_i == '0)
					begin
						next_state = FLT_HIGH;
						next_level = 1'b1;
					end
					else
					begin
						next_state = FLT_RISING;
						next_cnt   = '0;
					end
				end
			end
			FLT_RISING:
			begin
				if (!stable)
					next_state = FLT_LOW; // see RULE_21
				else if (tick_ms_i)
				begin
					if (cnt + DW'(1) >= on_delay_i)
					begin
						next_state = FLT_HIGH; // see RULE_01
						next_level = 1'b1;
					end
					else
						next_cnt = cnt + DW'(1);
				end
			end
			FLT_HIGH:
			begin
				if (!stable)
				begin
					if (off_delay_i == '0)
					begin
						next_state = FLT_LOW;
						next_level = 1'b0;
					end
					else
					begin
						next_state = FLT_FALLING;
						next_cnt   = '0;
					end
				end
			end
			FLT_FALLING:
			begin
				if (stable)
					next_state = FLT_HIGH; // see RULE_21
				else if (tick_ms_i)
				begin
					if (cnt + DW'(1) >= off_delay_i)
					begin
						next_state = FLT_LOW; // see RULE_02
						next_level = 1'b0;
					end
					else
						next_cnt = cnt + DW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			state   <= FLT_LOW;
			cnt     <= '0;
			level_o <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			cnt     <= next_cnt;
			level_o <= next_level;
		end
	end

	AST_ON_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_01
		(state == FLT_RISING) |-> !level_o)
		else $error("output rose before on delay expired");
	AST_OFF_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_02
		(state == FLT_FALLING) |-> level_o)
		else $error("output fell before off delay expired");
endmodule

// *** design/digital_input_channel_map.sv ***
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "dic_defines.svh"
// How it works
// RULE_01: each channel delays rising edges by its on delay, filtering short pulses.
// RULE_02: each channel delays falling edges by its off delay, stretching short pulses.
// RULE_03: on fault the substitute value 0 or 1 is reported, always invalid. A simulated channel reports sim_stat instead, which can be valid over a fault.
// RULE_04: simulation reports a configured value with a configured valid or invalid status.
// RULE_05: fifteen independent channels, each with own settings and own status bit.
// RULE_06: values and statuses are forwarded to the com unit every 6.5 ms.
// RULE_07: inputs toggling up to 50 Hz are acquired; polling may lower it.
// RULE_08: two byte image: statuses 1..15 then collective error in bit 15.
// RULE_09: the module has no output data bytes, input image only.
// RULE_10: master reads values and statuses from allocated or slot-based ranges.
// RULE_11: allocated bits read by code 2 starting at legacy reference 10001.
// RULE_12: allocated words read by code 3 at 1024 or 46001.
// RULE_13: slot bits by code 2 at 5120/16001 plus 16 times slot plus bit-1.
// RULE_14: slot status bits by code 2 at 2048/14001 plus 8 times slot plus bit-1.
// RULE_15: status and type words by code 4 at 768/35200 and 1024/35300 plus slot.
// RULE_16: every area has direct and legacy notation; both sides must agree.
// RULE_17: on fault follow error mode: current, substitute, or last valid value.
// RULE_18: inversion complements the conditioned input level.
// RULE_19: normal passes the real input, simulation replaces it with the simulated value.
// RULE_20: order is input, delays, inversion, fault or simulation, status; collective is OR.
// RULE_21: delays count whole milliseconds and restart when input returns early.
module digital_input_channel_map
	import dic_pkg::*;
#(
	parameter int        CH         = 15,
	parameter int        DW         = 16,
	parameter int        TICK_CYC   = `TICK_MS_CYCLES,
	parameter int        REFRESH_CYC = `REFRESH_CYCLES,
	parameter logic [15:0] MODULE_TYPE = 16'h00A5 // arbitrary identity value
)(
	input  wire logic          clk_sys_i,
	input  wire logic          rstn_i,
	input  wire logic [CH-1:0] field_i,
	input  wire logic [CH-1:0] fault_i,
	input  wire logic [7:0]    addr_i,
	input  wire logic [15:0]   wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic [15:0]        rdata_o,
	output logic [15:0]        image_o,
	output logic [CH-1:0]      value_o,
	output logic               refresh_o
);
	// configuration
	logic [CH-1:0]  mode_lo;
	logic [CH-1:0]  mode_hi;
	logic [CH-1:0]  invert;
	logic [CH-1:0]  sim_en;
	logic [CH-1:0]  sim_val;
	logic [CH-1:0]  sim_stat;
	logic [CH-1:0]  subst_val;
	logic [CH-1:0]  fault_force;
	logic [DW-1:0]  on_dly [CH];
	logic [DW-1:0]  off_dly [CH];
	logic [CH-1:0]  next_mode_lo;
	logic [CH-1:0]  next_mode_hi;
	logic [CH-1:0]  next_invert;
	logic [CH-1:0]  next_sim_en;
	logic [CH-1:0]  next_sim_val;
	logic [CH-1:0]  next_sim_stat;
	logic [CH-1:0]  next_subst_val;
	logic [CH-1:0]  next_fault_force;
	logic [DW-1:0]  next_on_dly [CH];
	logic [DW-1:0]  next_off_dly [CH];
	// timing
	logic [31:0]    tick_cnt;
	logic [31:0]    next_tick_cnt;
	logic           tick_ms;
	logic           next_tick_ms;
	logic [31:0]    ref_cnt;
	logic [31:0]    next_ref_cnt;
	logic           next_refresh;
	// fault sync and channel path
	logic [CH-1:0]  flt_s0;
	logic [CH-1:0]  flt_s1;
	logic [CH-1:0]  flt_s2;
	logic [CH-1:0]  fault_st;
	logic [CH-1:0]  next_fault_st;
	logic [CH-1:0]  filt;
	logic [CH-1:0]  last_valid;
	logic [CH-1:0]  next_last_valid;
	logic [CH-1:0]  ch_val;
	logic [CH-1:0]  ch_ok;
	logic [15:0]    next_image;
	logic [CH-1:0]  next_value;
	logic [15:0]    next_rdata;

	// per-channel delay filters
	genvar g;
	generate
		for (g = 0; g < CH; g++)
		begin : gen_ch
			delay_filter #(
				.DW (DW)
			) u_filt (
				.clk_sys_i   (clk_sys_i),
				.rstn_i      (rstn_i),
				.tick_ms_i   (tick_ms),
				.pin_i       (field_i[g]), // see RULE_07
				.on_delay_i  (on_dly[g]),
				.off_delay_i (off_dly[g]),
				.level_o     (filt[g])
			); // see RULE_05
		end
	endgenerate

	// millisecond tick and refresh cycle
	always_comb
	begin
		next_tick_ms  = 1'b0;
		next_tick_cnt = tick_cnt + 32'h1;
		if (tick_cnt >= 32'(TICK_CYC - 1))
		begin
			next_tick_cnt = 32'h0;
			next_tick_ms  = 1'b1; // see RULE_21
		end
		next_refresh = 1'b0;
		next_ref_cnt = ref_cnt + 32'h1;
		if (ref_cnt >= 32'(REFRESH_CYC - 1))
		begin
			next_ref_cnt = 32'h0;
			next_refresh = 1'b1; // see RULE_06
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			tick_cnt  <= 32'h0;
			tick_ms   <= 1'b0;
			ref_cnt   <= 32'h0;
			refresh_o <= 1'b0;
		end
		else
		begin
			tick_cnt  <= next_tick_cnt;
			tick_ms   <= next_tick_ms;
			ref_cnt   <= next_ref_cnt;
			refresh_o <= next_refresh;
		end
	end

	// fault inputs come from the field side, so sync them too
	always_comb
	begin
		next_fault_st = fault_st;
		for (int i = 0; i < CH; i++)
			if (flt_s1[i] == flt_s2[i])
				next_fault_st[i] = flt_s2[i];
	end

	// channel value path: delay, invert, fault/simulation choice
	always_comb
	begin
		next_last_valid = last_valid;
		ch_val          = '0;
		ch_ok           = '0;
		for (int i = 0; i < CH; i++)
		begin
			logic live;
			logic flt;
			live = filt[i] ^ invert[i]; // see RULE_18
			flt  = fault_st[i] | fault_force[i];
			ch_val[i] = live;
			ch_ok[i]  = !flt;
			if (sim_en[i])
			begin
				ch_val[i] = sim_val[i]; // see RULE_19
				ch_ok[i]  = sim_stat[i]; // see RULE_04
			end
			else if (flt)
			begin
				unique case ({mode_hi[i], mode_lo[i]})
					ERR_MODE_SUBST:      ch_val[i] = subst_val[i]; // see RULE_03
					ERR_MODE_LAST_VALID: ch_val[i] = last_valid[i]; // see RULE_17
					default:             ch_val[i] = live;
				endcase
				ch_ok[i] = 1'b0; // see RULE_03
			end
			else
				next_last_valid[i] = live;
		end
	end

	// image: status bits and collective error in the top bit
	always_comb
	begin
		next_image = image_o;
		next_value = value_o;
		if (refresh_o)
		begin
			next_image = {|(~ch_ok), ch_ok}; // see RULE_08
			next_value = ch_val; // see RULE_20
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			flt_s0     <= '0;
			flt_s1     <= '0;
			flt_s2     <= '0;
			fault_st   <= '0;
			last_valid <= '0;
			image_o    <= `IMAGE_RESET; // no data yet: all invalid, so the collective bit agrees
			value_o    <= '0;
		end
		else
		begin
			flt_s0     <= fault_i;
			flt_s1     <= flt_s0;
			flt_s2     <= flt_s1;
			fault_st   <= next_fault_st;
			last_valid <= next_last_valid;
			image_o    <= next_image;
			value_o    <= next_value;
		end
	end

	// register writes; image and values are read only, no output bytes exist
	always_comb
	begin
		next_mode_lo     = mode_lo;
		next_mode_hi     = mode_hi;
		next_invert      = invert;
		next_sim_en      = sim_en;
		next_sim_val     = sim_val;
		next_sim_stat    = sim_stat;
		next_subst_val   = subst_val;
		next_fault_force = fault_force;
		next_on_dly      = on_dly;
		next_off_dly     = off_dly;
		if (wr_i)
		begin
			unique case (addr_i)
				`REG_MODE:        next_mode_lo     = wdata_i[CH-1:0];
				`REG_MODE_HI:     next_mode_hi     = wdata_i[CH-1:0];
				`REG_INVERT:      next_invert      = wdata_i[CH-1:0];
				`REG_SIM_ENABLE:  next_sim_en      = wdata_i[CH-1:0];
				`REG_SIM_VALUE:   next_sim_val     = wdata_i[CH-1:0];
				`REG_SIM_STATUS:  next_sim_stat    = wdata_i[CH-1:0];
				`REG_SUBST_VALUE: next_subst_val   = wdata_i[CH-1:0];
				`REG_FAULT_FORCE: next_fault_force = wdata_i[CH-1:0];
				default:          next_mode_lo     = mode_lo; // see RULE_09
			endcase
			for (int i = 0; i < CH; i++)
			begin
				if (addr_i == (`REG_ON_DELAY_BASE + 8'(i)))
					next_on_dly[i] = wdata_i[DW-1:0];
				if (addr_i == (`REG_OFF_DELAY_BASE + 8'(i)))
					next_off_dly[i] = wdata_i[DW-1:0];
			end
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_comb
	begin
		next_rdata = 16'h0000;
		if (rd_i)
		begin
			unique case (addr_i)
				`REG_MODE:        next_rdata = 16'(mode_lo);
				`REG_MODE_HI:     next_rdata = 16'(mode_hi);
				`REG_INVERT:      next_rdata = 16'(invert);
				`REG_SIM_ENABLE:  next_rdata = 16'(sim_en);
				`REG_SIM_VALUE:   next_rdata = 16'(sim_val);
				`REG_SIM_STATUS:  next_rdata = 16'(sim_stat);
				`REG_SUBST_VALUE: next_rdata = 16'(subst_val);
				`REG_FAULT_FORCE: next_rdata = 16'(fault_force);
				`REG_IMAGE:       next_rdata = image_o; // see RULE_10 RULE_14
				`REG_VALUES:      next_rdata = 16'(value_o); // see RULE_11 RULE_12 RULE_13
				`REG_TYPE:        next_rdata = MODULE_TYPE; // see RULE_15
				default:          next_rdata = 16'h0000;
			endcase
			for (int i = 0; i < CH; i++)
			begin
				if (addr_i == (`REG_ON_DELAY_BASE + 8'(i)))
					next_rdata = 16'(on_dly[i]);
				if (addr_i == (`REG_OFF_DELAY_BASE + 8'(i)))
					next_rdata = 16'(off_dly[i]);
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			mode_lo     <= '0;
			mode_hi     <= '0;
			invert      <= '0;
			sim_en      <= '0;
			sim_val     <= '0;
			sim_stat    <= '0;
			subst_val   <= '0;
			fault_force <= '0;
			rdata_o     <= 16'h0000;
			for (int i = 0; i < CH; i++)
			begin
				on_dly[i]  <= '0;
				off_dly[i] <= '0;
			end
		end
		else
		begin
			mode_lo     <= next_mode_lo;
			mode_hi     <= next_mode_hi;
			invert      <= next_invert;
			sim_en      <= next_sim_en;
			sim_val     <= next_sim_val;
			sim_stat    <= next_sim_stat;
			subst_val   <= next_subst_val;
			fault_force <= next_fault_force;
			rdata_o     <= next_rdata;
			on_dly      <= next_on_dly;
			off_dly     <= next_off_dly;
		end
	end

	sequence s_refresh;
		refresh_o;
	endsequence
	AST_REFRESH_PERIOD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_06
		s_refresh |=> !refresh_o [*8])
		else $error("refresh pulses too close");
	AST_COLLECTIVE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_08
		image_o[`IMG_COLLECTIVE_BIT] == |(~image_o[CH-1:0]))
		else $error("collective error does not match channel statuses");
	AST_IMAGE_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_06
		!refresh_o |=> $stable(image_o))
		else $error("image changed outside refresh");
	AST_SUBST_INVALID: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_03
		(refresh_o && fault_force[0] && !sim_en[0]) |=> !image_o[0])
		else $error("faulted channel reported as valid");
	AST_SIM_VALUE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_04
		(refresh_o && sim_en[0]) |=> (value_o[0] == $past(sim_val[0]) && image_o[0] == $past(sim_stat[0])))
		else $error("simulated value or status not reported");
	AST_INVERT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_18
		(refresh_o && !sim_en[1] && !(fault_st[1] | fault_force[1])) |=> value_o[1] == $past(filt[1] ^ invert[1]))
		else $error("inversion not applied");
	AST_READ_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_10
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data outside read cycle");
	AST_TICK: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE_21
		tick_ms |=> !tick_ms)
		else $error("millisecond tick longer than one cycle");
endmodule

// *** verification/com_unit_model.sv ***
`timescale 1ns/1ps
// com unit side: takes each refreshed image one cycle after the refresh pulse
module com_unit_model
(
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        refresh_i,
	input  wire logic [15:0] image_i,
	input  wire logic [14:0] value_i,
	input  wire logic        clr_i,
	output logic      [15:0] snap_o,
	output logic      [14:0] seen_hi_o,
	output logic      [14:0] seen_lo_o,
	output logic      [31:0] gap_o
);
	logic        ref_d;
	logic [31:0] cnt;

	// refresh spacing is measured so the bench can check the forwarding period
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			cnt   <= 32'h0;
			gap_o <= 32'h0;
			ref_d <= 1'b0;
		end
		else
		begin
			ref_d <= refresh_i;
			cnt   <= refresh_i ? 32'h0 : cnt + 32'h1;
			if (refresh_i)
				gap_o <= cnt + 32'h1;
		end
	end

	// sticky masks catch short pulses that a single snapshot would miss
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i || clr_i)
		begin
			snap_o    <= 16'h0;
			seen_hi_o <= 15'h0;
			seen_lo_o <= 15'h0;
		end
		else if (ref_d)
		begin
			snap_o    <= image_i;
			seen_hi_o <= seen_hi_o | value_i;
			seen_lo_o <= seen_lo_o | ~value_i;
		end
	end
endmodule

// *** verification/digital_input_channel_map_tb.sv ***
`timescale 1ns/1ps
module digital_input_channel_map_tb;
	import dic_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [14:0] field_i = 15'h0;
	logic [14:0] fault_i = 15'h0;
	logic [7:0]  addr_i = 8'h0;
	logic [15:0] wdata_i = 16'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        clr = 1'b0;
	logic [15:0] rdata_o;
	logic [15:0] image_o;
	logic [14:0] value_o;
	logic        refresh_o;
	logic [15:0] snap;
	logic [14:0] seen_hi;
	logic [14:0] seen_lo;
	logic [31:0] gap;
	logic [15:0] rv;
	int          bad_count = 0;
	int          n_tests = 0;

	always #12.5 clk_sys_i = ~clk_sys_i;

	// short tick and refresh keep the run small; refresh shorter than test pulses but above the spacing check
	digital_input_channel_map #(.TICK_CYC(10), .REFRESH_CYC(9), .MODULE_TYPE(16'h1234)) digital_input_channel_map_i
	(
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.field_i   (field_i),
		.fault_i   (fault_i),
		.addr_i    (addr_i),
		.wdata_i   (wdata_i),
		.wr_i      (wr_i),
		.rd_i      (rd_i),
		.rdata_o   (rdata_o),
		.image_o   (image_o),
		.value_o   (value_o),
		.refresh_o (refresh_o)
	);

	com_unit_model com_unit_model_i
	(
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.refresh_i (refresh_o),
		.image_i   (image_o),
		.value_i   (value_o),
		.clr_i     (clr),
		.snap_o    (snap),
		.seen_hi_o (seen_hi),
		.seen_lo_o (seen_lo),
		.gap_o     (gap)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask

	// read data is only valid in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic wait_ref(input int n);
		repeat (n) @(posedge clk_sys_i iff refresh_o === 1'b1);
		@(posedge clk_sys_i);
		#1;
	endtask

	// six refreshes cover sync plus a 3 ms delay at any tick phase
	task automatic expect_out(input logic [14:0] v, input logic [15:0] img);
		wait_ref(6);
		check({17'h0, value_o}, {17'h0, v});
		check({16'h0, image_o}, {16'h0, img});
		check({16'h0, snap}, {16'h0, img});
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog far beyond the expected run of about a thousand cycles
	initial
	begin
		#(20000 * 25);
		bad_count++;
		print_verdict();
	end

	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rd(8'h30, rv);
		check({16'h0, rv}, 32'h8000);
		expect_out(15'h0000, 16'h7FFF);
		check(gap, 32'h9);
		rd(8'h7F, rv);
		check({16'h0, rv}, 32'h0);
		rd(8'h32, rv);
		check({16'h0, rv}, 32'h1234);
		wr(8'h30, 16'h0000);
		@(posedge clk_sys_i) field_i <= 15'h2A5A;
		expect_out(15'h2A5A, 16'h7FFF);
		rd(8'h31, rv);
		check({16'h0, rv}, 32'h2A5A);
		rd(8'h30, rv);
		check({16'h0, rv}, 32'h7FFF);
		wr(8'h01, 16'h0003);
		expect_out(15'h2A59, 16'h7FFF);
		wr(8'h01, 16'h0000);
		// channel 2 faults; walk through the three error modes
		wr(8'h00, 16'h0002);
		wr(8'h07, 16'h0002);
		@(posedge clk_sys_i) fault_i <= 15'h0002;
		repeat (8) @(posedge clk_sys_i);
		field_i <= 15'h2A58;
		expect_out(15'h2A5A, 16'hFFFD);
		@(posedge clk_sys_i) field_i <= 15'h2A5A;
		wr(8'h07, 16'h0000);
		wr(8'h05, 16'h0000);
		expect_out(15'h2A58, 16'hFFFD);
		wr(8'h05, 16'h0002);
		@(posedge clk_sys_i) field_i <= 15'h2A58;
		expect_out(15'h2A5A, 16'hFFFD);
		@(posedge clk_sys_i) field_i <= 15'h2A5A;
		wr(8'h00, 16'h0000);
		@(posedge clk_sys_i) field_i <= 15'h2A58;
		expect_out(15'h2A58, 16'hFFFD);
		@(posedge clk_sys_i) field_i <= 15'h2A5A;
		@(posedge clk_sys_i) fault_i <= 15'h0000;
		expect_out(15'h2A5A, 16'h7FFF);
		// channel 1 forced faulty by register; error mode 10 still passes the live value
		wr(8'h07, 16'h0001);
		wr(8'h06, 16'h0001);
		rd(8'h06, rv);
		check({16'h0, rv}, 32'h1);
		expect_out(15'h2A5A, 16'hFFFE);
		wr(8'h06, 16'h0000);
		wr(8'h07, 16'h0000);
		// channels 1 and 3 simulated high, first invalid, then valid over a fault
		wr(8'h02, 16'h0005);
		wr(8'h03, 16'h0005);
		wr(8'h04, 16'h0000);
		expect_out(15'h2A5F, 16'hFFFA);
		wr(8'h04, 16'h0005);
		@(posedge clk_sys_i) fault_i <= 15'h0004;
		expect_out(15'h2A5F, 16'h7FFF);
		wr(8'h02, 16'h0000);
		@(posedge clk_sys_i) fault_i <= 15'h0000;
		expect_out(15'h2A5A, 16'h7FFF);
		// channel 9: 3 ms delays are 30 cycles; a 15 cycle pulse must vanish
		wr(8'h18, 16'h0003);
		wr(8'h28, 16'h0003);
		rd(8'h28, rv);
		check({16'h0, rv}, 32'h3);
		wait_ref(1);
		@(posedge clk_sys_i) clr <= 1'b1;
		@(posedge clk_sys_i) clr <= 1'b0;
		field_i <= 15'h2B5A;
		repeat (15) @(posedge clk_sys_i);
		field_i <= 15'h2A5A;
		expect_out(15'h2A5A, 16'h7FFF);
		check({17'h0, seen_hi}, 32'h2A5A);
		@(posedge clk_sys_i) field_i <= 15'h2B5A;
		expect_out(15'h2B5A, 16'h7FFF);
		wait_ref(4);
		@(posedge clk_sys_i) clr <= 1'b1;
		@(posedge clk_sys_i) clr <= 1'b0;
		field_i <= 15'h2A5A;
		repeat (15) @(posedge clk_sys_i);
		field_i <= 15'h2B5A;
		expect_out(15'h2B5A, 16'h7FFF);
		check({17'h0, seen_lo}, 32'h54A5);
		@(posedge clk_sys_i) field_i <= 15'h2A5A;
		expect_out(15'h2A5A, 16'h7FFF);
		print_verdict();
	end
endmodule
